/* File: rtl/epd_top.sv */
// Transmit and receive poll demand, receive list base and suspend control of an Ethernet DMA.
// Assumes descriptor pointers, fetch answers and suspend events come from the DMA on MCLK_I.
`timescale 1ns/100ps

module epd_top
  import epd_pkg::*;
#(
  parameter int BUS_ALIGN_BITS = 2
) (
  input  wire logic           MCLK_I,
  input  wire logic           RESETN_I,
  input  wire logic           PSEL_I,
  input  wire logic           PENABLE_I,
  input  wire logic           PWRITE_I,
  input  wire logic [15:0]    PADDR_I,
  input  wire logic [31:0]    PWDATA_I,
  output logic      [31:0]    PRDATA_O,
  output logic                PREADY_O,
  output logic                PSLVERR_O,
  output logic                IRQ_O,
  input  wire logic [31:0]    CUR_TX_DESC_PTR_I,
  input  wire logic [31:0]    CUR_RX_DESC_PTR_I,
  input  wire logic           TX_UNDERFLOW_I,
  input  wire logic           TX_DESC_UNAVAIL_I,
  input  wire logic           RX_DESC_UNAVAIL_I,
  input  wire epd_fetch_rsp_t TX_FETCH_RSP_I,
  input  wire epd_fetch_rsp_t RX_FETCH_RSP_I,
  output epd_fetch_req_t      TX_FETCH_O,
  output epd_fetch_req_t      RX_FETCH_O,
  output logic                TX_ACTIVE_O,
  output logic                RX_ACTIVE_O,
  output logic      [31:0]    RX_LIST_BASE_O
);

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic        access;
  logic        commit;
  logic        wr_commit;
  logic        mapped;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic [31:0] rd_word;

  logic [29:0] rx_base_q;
  logic [29:0] rx_base_d;
  logic [31:0] rx_base_out_q;
  logic [31:0] rx_base_out_d;
  logic [1:0]  run_en_q;
  logic [1:0]  run_en_d;
  logic [16:0] status_q;
  logic [16:0] status_d;
  logic [16:0] mask_q;
  logic [16:0] mask_d;
  logic [16:0] status_set;
  logic [16:0] status_clr;
  logic        irq_q;
  logic        irq_d;
  logic [2:0]  tx_code;

  logic [1:0]  poll_wr;
  logic [1:0]  stall_evt;
  logic [1:0]  unavail_seen;
  logic [1:0]  fetch_ack;
  logic [1:0]  fetch_own;
  logic [31:0] cur_ptr [2];
  epd_state_t  state_q [2];
  epd_fetch_req_t fetch_q [2];

  // One wait state keeps PRDATA and PREADY on flip-flops
  assign access    = PSEL_I & PENABLE_I;
  assign commit    = access & pready_q;
  assign wr_commit = commit & PWRITE_I & ~pslverr_q;

  always_comb begin
    mapped  = 1'b1;
    rd_word = EPD_REG_RESET;
    case (PADDR_I)
      EPD_TX_POLL_KICK_OFS: rd_word = EPD_REG_RESET;
      EPD_RX_POLL_KICK_OFS: rd_word = EPD_REG_RESET;
      EPD_RX_LIST_BASE_OFS: rd_word = {rx_base_q, 2'h0};
      EPD_STATUS_OFS: begin
        rd_word                                  = {15'h0000, status_q};
        rd_word[EPD_TX_STATE_LSB +: 3]           = tx_code;
      end
      EPD_CONTROL_OFS: begin
        rd_word[EPD_TX_START_BIT]                = run_en_q[0];
        rd_word[EPD_RX_START_BIT]                = run_en_q[1];
      end
      EPD_INT_MASK_OFS: rd_word = {15'h0000, mask_q};
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    pready_d  = access & ~pready_q;
    pslverr_d = access & ~pready_q & ~mapped;
    prdata_d  = prdata_q;
    if (access & ~pready_q) begin
      prdata_d = (PWRITE_I | ~mapped) ? EPD_REG_RESET : rd_word;
    end
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= EPD_REG_RESET;
    end else begin
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  assign poll_wr[0] = wr_commit & (PADDR_I == EPD_TX_POLL_KICK_OFS);
  assign poll_wr[1] = wr_commit & (PADDR_I == EPD_RX_POLL_KICK_OFS);

  always_comb begin
    rx_base_d     = rx_base_q;
    run_en_d      = run_en_q;
    mask_d        = mask_q;
    status_clr    = 17'h00000;
    if (wr_commit) begin
      case (PADDR_I)
        EPD_RX_LIST_BASE_OFS: rx_base_d = PWDATA_I[31:EPD_LIST_BASE_LSB];
        EPD_CONTROL_OFS: begin
          run_en_d[0] = PWDATA_I[EPD_TX_START_BIT];
          run_en_d[1] = PWDATA_I[EPD_RX_START_BIT];
        end
        EPD_INT_MASK_OFS: mask_d     = PWDATA_I[EPD_STATUS_W-1:0];
        EPD_STATUS_OFS:   status_clr = PWDATA_I[EPD_STATUS_W-1:0];
        default: ;
      endcase
    end
    // Low bits forced to zero so fetches start on a bus word
    rx_base_out_d = {rx_base_q, 2'h0};
    rx_base_out_d[BUS_ALIGN_BITS-1:0] = '0;
  end

  // ****************************************************************
  // Sticky status and interrupt
  // ****************************************************************
  always_comb begin
    status_set                       = 17'h00000;
    status_set[EPD_TX_UNAVAIL_BIT]   = unavail_seen[0];
    status_set[EPD_TX_UNDERFLOW_BIT] = TX_UNDERFLOW_I & (state_q[0] == EPD_ST_RUNNING);
    status_set[EPD_RX_UNAVAIL_BIT]   = unavail_seen[1];
    // Set wins over a clear in the same cycle
    status_d = (status_q & ~status_clr) | status_set;
    irq_d    = |(status_d & mask_q);
    case (state_q[0])
      EPD_ST_FETCH:     tx_code = EPD_TS_FETCHING;
      EPD_ST_RUNNING:   tx_code = EPD_TS_RUNNING;
      EPD_ST_SUSPENDED: tx_code = EPD_TS_SUSPENDED;
      default:          tx_code = EPD_TS_STOPPED;
    endcase
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      rx_base_q     <= 30'h00000000;
      rx_base_out_q <= EPD_REG_RESET;
      run_en_q      <= 2'h0;
      mask_q        <= EPD_MASK_RESET;
      status_q      <= EPD_STATUS_RESET;
      irq_q         <= 1'b0;
    end else begin
      rx_base_q     <= rx_base_d;
      rx_base_out_q <= rx_base_out_d;
      run_en_q      <= run_en_d;
      mask_q        <= mask_d;
      status_q      <= status_d;
      irq_q         <= irq_d;
    end
  end

  // ****************************************************************
  // Per-direction suspend and poll control
  // ****************************************************************
  assign stall_evt[0] = TX_UNDERFLOW_I | TX_DESC_UNAVAIL_I;
  assign stall_evt[1] = RX_DESC_UNAVAIL_I;
  assign fetch_ack[0] = TX_FETCH_RSP_I.ack;
  assign fetch_ack[1] = RX_FETCH_RSP_I.ack;
  assign fetch_own[0] = TX_FETCH_RSP_I.dma_owned;
  assign fetch_own[1] = RX_FETCH_RSP_I.dma_owned;
  assign cur_ptr[0]   = CUR_TX_DESC_PTR_I;
  assign cur_ptr[1]   = CUR_RX_DESC_PTR_I;

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic           pend_q;
    logic           pend_d;
    epd_state_t     state_d;
    epd_fetch_req_t fetch_d;
    logic           unav_q;
    logic           unav_d;

    always_comb begin
      state_d = state_q[ch];
      fetch_d = fetch_q[ch];
      // Command lives until the fetch starts or is dropped
      pend_d  = pend_q | poll_wr[ch];
      unav_d  = 1'b0;
      case (state_q[ch])
        EPD_ST_STOPPED: begin
          pend_d = 1'b0;
          if (run_en_q[ch]) begin
            state_d = EPD_ST_FETCH;
            fetch_d = '{req: 1'b1, addr: cur_ptr[ch]};
          end
        end
        EPD_ST_RUNNING: begin
          pend_d = 1'b0;
          if (stall_evt[ch]) begin
            state_d = EPD_ST_SUSPENDED;
            unav_d  = (ch == 0) ? TX_DESC_UNAVAIL_I : RX_DESC_UNAVAIL_I;
          end
        end
        EPD_ST_SUSPENDED: begin
          if (pend_q) begin
            state_d = EPD_ST_FETCH;
            fetch_d = '{req: 1'b1, addr: cur_ptr[ch]};
            pend_d  = 1'b0;
          end
        end
        EPD_ST_FETCH: begin
          // A kick during a fetch would duplicate it
          pend_d = 1'b0;
          if (fetch_ack[ch]) begin
            fetch_d.req = 1'b0;
            if (fetch_own[ch]) begin
              state_d = EPD_ST_RUNNING;
            end else begin
              state_d = EPD_ST_SUSPENDED;
              unav_d  = 1'b1;
            end
          end
        end
        default: state_d = EPD_ST_STOPPED;
      endcase
      if (!run_en_q[ch]) begin
        state_d     = EPD_ST_STOPPED;
        fetch_d.req = 1'b0;
        unav_d      = 1'b0;
      end
    end

    always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
        state_q[ch] <= EPD_ST_STOPPED;
        fetch_q[ch] <= '{req: 1'b0, addr: 32'h00000000};
        pend_q      <= 1'b0;
        unav_q      <= 1'b0;
      end else begin
        state_q[ch] <= state_d;
        fetch_q[ch] <= fetch_d;
        pend_q      <= pend_d;
        unav_q      <= unav_d;
      end
    end

    assign unavail_seen[ch] = unav_q;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  logic tx_act_q;
  logic rx_act_q;

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_act_q <= 1'b0;
      rx_act_q <= 1'b0;
    end else begin
      tx_act_q <= (state_q[0] == EPD_ST_RUNNING);
      rx_act_q <= (state_q[1] == EPD_ST_RUNNING);
    end
  end

  assign PRDATA_O       = prdata_q;
  assign PREADY_O       = pready_q;
  assign PSLVERR_O      = pslverr_q;
  assign IRQ_O          = irq_q;
  assign TX_FETCH_O     = fetch_q[0];
  assign RX_FETCH_O     = fetch_q[1];
  assign TX_ACTIVE_O    = tx_act_q;
  assign RX_ACTIVE_O    = rx_act_q;
  assign RX_LIST_BASE_O = rx_base_out_q;

endmodule : epd_top

/* File: pkg/epd_pkg.sv */
// Constants, types and register map of the poll-demand and receive list base block.
// Assumes a 32-bit APB with byte addresses and the rest of the DMA on the same clock.
package epd_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [15:0] EPD_TX_POLL_KICK_OFS  = 16'h1004;
  localparam logic [15:0] EPD_RX_POLL_KICK_OFS  = 16'h1008;
  localparam logic [15:0] EPD_RX_LIST_BASE_OFS  = 16'h100C;
  localparam logic [15:0] EPD_STATUS_OFS        = 16'h1014;
  localparam logic [15:0] EPD_CONTROL_OFS       = 16'h1018;
  localparam logic [15:0] EPD_INT_MASK_OFS      = 16'h101C;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          EPD_TX_UNAVAIL_BIT    = 2;
  localparam int          EPD_TX_UNDERFLOW_BIT  = 5;
  localparam int          EPD_RX_UNAVAIL_BIT    = 7;
  localparam int          EPD_STATUS_W          = 17;
  localparam int          EPD_TX_STATE_LSB      = 20;
  localparam int          EPD_RX_START_BIT      = 1;
  localparam int          EPD_TX_START_BIT      = 13;
  localparam int          EPD_LIST_BASE_LSB     = 2;
  localparam logic [31:0] EPD_REG_RESET         = 32'h00000000;
  localparam logic [16:0] EPD_STATUS_RESET      = 17'h00000;
  localparam logic [16:0] EPD_MASK_RESET        = 17'h00000;

  // ****************************************************************
  // Transmit process state codes
  // ****************************************************************
  localparam logic [2:0]  EPD_TS_STOPPED        = 3'h0;
  localparam logic [2:0]  EPD_TS_FETCHING       = 3'h1;
  localparam logic [2:0]  EPD_TS_RUNNING        = 3'h3;
  localparam logic [2:0]  EPD_TS_SUSPENDED      = 3'h6;

  // Channel states, Gray along stopped-running-suspended-fetch; fetch to running flips both bits
  typedef enum logic [1:0] {
    EPD_ST_STOPPED   = 2'h0,
    EPD_ST_RUNNING   = 2'h1,
    EPD_ST_SUSPENDED = 2'h3,
    EPD_ST_FETCH     = 2'h2
  } epd_state_t;

  // Descriptor fetch request to host memory
  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } epd_fetch_req_t;

  // Descriptor fetch answer: ack pulse with the ownership bit
  typedef struct packed {
    logic ack;
    logic dma_owned;
  } epd_fetch_rsp_t;

endpackage : epd_pkg

/* File: testbench/epd_top_monitor.sv */
// Checker of the poll-demand block, bound to epd_top.
// Assumes descriptor pointers stay steady while a fetch is pending.
`timescale 1ns/100ps
module epd_top_monitor
  import epd_pkg::*;
#(
  parameter int BUS_ALIGN_BITS = 2
) (
  input  wire logic           MCLK_I,
  input  wire logic           RESETN_I,
  input  wire logic [31:0]    CUR_TX_DESC_PTR_I,
  input  wire logic [31:0]    CUR_RX_DESC_PTR_I,
  input  wire logic           TX_UNDERFLOW_I,
  input  wire logic           RX_DESC_UNAVAIL_I,
  input  wire epd_fetch_rsp_t TX_FETCH_RSP_I,
  input  wire epd_fetch_rsp_t RX_FETCH_RSP_I,
  input  wire epd_fetch_req_t TX_FETCH_O,
  input  wire epd_fetch_req_t RX_FETCH_O,
  input  wire logic           TX_ACTIVE_O,
  input  wire logic           RX_ACTIVE_O,
  input  wire logic [31:0]    RX_LIST_BASE_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);

  property p_tx_addr; $rose(TX_FETCH_O.req) |-> TX_FETCH_O.addr == CUR_TX_DESC_PTR_I; endproperty
  a_tx_addr: assert property (p_tx_addr) else $error("tx fetch address wrong");
  property p_tx_resume; TX_FETCH_O.req && TX_FETCH_RSP_I.ack && TX_FETCH_RSP_I.dma_owned |-> ##2 TX_ACTIVE_O; endproperty
  a_tx_resume: assert property (p_tx_resume) else $error("tx did not resume");
  property p_tx_susp; TX_ACTIVE_O && TX_UNDERFLOW_I |-> ##2 !TX_ACTIVE_O; endproperty
  a_tx_susp: assert property (p_tx_susp) else $error("tx did not suspend");
  property p_ack_drop; TX_FETCH_RSP_I.ack && TX_FETCH_O.req |=> !TX_FETCH_O.req; endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("tx fetch held after ack");
  property p_rx_addr; $rose(RX_FETCH_O.req) |-> RX_FETCH_O.addr == CUR_RX_DESC_PTR_I; endproperty
  a_rx_addr: assert property (p_rx_addr) else $error("rx fetch address wrong");
  property p_rx_resume; RX_FETCH_O.req && RX_FETCH_RSP_I.ack && RX_FETCH_RSP_I.dma_owned |-> ##2 RX_ACTIVE_O; endproperty
  a_rx_resume: assert property (p_rx_resume) else $error("rx did not resume");
  property p_rx_susp; RX_ACTIVE_O && RX_DESC_UNAVAIL_I |-> ##2 !RX_ACTIVE_O; endproperty
  a_rx_susp: assert property (p_rx_susp) else $error("rx did not suspend");
  property p_base_align; RX_LIST_BASE_O[BUS_ALIGN_BITS-1:0] == '0; endproperty
  a_base_align: assert property (p_base_align) else $error("list base not aligned");
  property p_no_dup; !(TX_ACTIVE_O && TX_FETCH_O.req) && !(RX_ACTIVE_O && RX_FETCH_O.req); endproperty
  a_no_dup: assert property (p_no_dup) else $error("fetch while running");
endmodule : epd_top_monitor

bind epd_top epd_top_monitor #(.BUS_ALIGN_BITS(BUS_ALIGN_BITS)) epd_top_monitor_inst (
  .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CUR_TX_DESC_PTR_I(CUR_TX_DESC_PTR_I),
  .CUR_RX_DESC_PTR_I(CUR_RX_DESC_PTR_I), .TX_UNDERFLOW_I(TX_UNDERFLOW_I),
  .RX_DESC_UNAVAIL_I(RX_DESC_UNAVAIL_I), .TX_FETCH_RSP_I(TX_FETCH_RSP_I), .RX_FETCH_RSP_I(RX_FETCH_RSP_I),
  .TX_FETCH_O(TX_FETCH_O), .RX_FETCH_O(RX_FETCH_O), .TX_ACTIVE_O(TX_ACTIVE_O), .RX_ACTIVE_O(RX_ACTIVE_O),
  .RX_LIST_BASE_O(RX_LIST_BASE_O));

/* File: testbench/epd_mem_model.sv */
// Host memory answering descriptor fetches of one channel.
// Assumes one fetch at a time; owner bit and latency come from the bench.
`timescale 1ns/100ps
module epd_mem_model
  import epd_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           rst_n_i,
  input  wire epd_fetch_req_t fetch_i,
  input  wire logic [3:0]     lat_i,
  input  wire logic           own_i,
  output epd_fetch_rsp_t      rsp_o
);
  logic [3:0] cnt_q;
  logic       hit;
  assign hit = fetch_i.req && !rsp_o.ack && (cnt_q == lat_i);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 4'h0;
      rsp_o <= '0;
    end else begin
      cnt_q <= (fetch_i.req && !rsp_o.ack) ? cnt_q + 4'h1 : 4'h0;
      rsp_o.ack <= hit;
      // Owner bit is void off ack, so keep it moving
      rsp_o.dma_owned <= hit ? own_i : ~rsp_o.dma_owned;
    end
  end
endmodule : epd_mem_model

/* File: testbench/epd_top_bench.sv */
// Self-checking bench of epd_top: APB master tasks and two memory models.
// Assumes the checker binds itself from its own file.
`timescale 1ns/100ps
module epd_top_bench
  import epd_pkg::*;
;
  localparam logic [31:0] TXP = 32'h2000_0010;
  localparam logic [31:0] RXP = 32'h3000_0040;
  localparam logic [31:0] SM  = 32'h0071_FFFF;
  logic           clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic           unf = 1'b0, ru = 1'b0, tu = 1'b0, own = 1'b1, rerr;
  logic [3:0]     lat = 4'h3;
  logic [15:0]    paddr = 16'h0000;
  logic [31:0]    pwdata = 32'h0, prdata, rdat, base;
  logic           pready, pslverr, irq, txa, rxa;
  epd_fetch_req_t txf, rxf;
  epd_fetch_rsp_t txr, rxr;
  int             fail_count = 0;
  int             n_compared = 0;

  always #50 clk = ~clk;

  epd_top #(.BUS_ALIGN_BITS(3)) epd_top_inst (
    .MCLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .IRQ_O(irq),
    .CUR_TX_DESC_PTR_I(TXP), .CUR_RX_DESC_PTR_I(RXP), .TX_UNDERFLOW_I(unf), .TX_DESC_UNAVAIL_I(tu),
    .RX_DESC_UNAVAIL_I(ru), .TX_FETCH_RSP_I(txr), .RX_FETCH_RSP_I(rxr), .TX_FETCH_O(txf),
    .RX_FETCH_O(rxf), .TX_ACTIVE_O(txa), .RX_ACTIVE_O(rxa), .RX_LIST_BASE_O(base));
  epd_mem_model tx_mem_inst (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(txf), .lat_i(lat), .own_i(own), .rsp_o(txr));
  epd_mem_model rx_mem_inst (.clk_i(clk), .rst_n_i(rst_n), .fetch_i(rxf), .lat_i(lat), .own_i(own), .rsp_o(rxr));

  // ****
  // Tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // No wait limit here; the watchdog ends a hung slave
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0);
    chk("read data", e, rdat & m);
    // Only the other list base slot is unmapped in this range
    chk("slave error", {31'h0, a == 16'h1010}, {31'h0, rerr});
  endtask : rd

  task automatic settle;
    repeat (16) @(posedge clk);
  endtask : settle

  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  // ****
  // Tests
  // ****
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int a = 32'h1004; a <= 32'h101C; a += 4) rd(16'(a), 32'h0);
    apb(1'b1, EPD_RX_LIST_BASE_OFS, 32'h8000_0004);
    rd(EPD_RX_LIST_BASE_OFS, 32'h8000_0004);
    chk("list base out", 32'h8000_0000, base);
    apb(1'b1, EPD_INT_MASK_OFS, 32'h0000_00A4);
    apb(1'b1, EPD_CONTROL_OFS, 32'h0000_2000);
    settle();
    apb(1'b1, EPD_TX_POLL_KICK_OFS, 32'hFFFF_FFFF);
    settle();
    rd(EPD_STATUS_OFS, 32'h0030_0000, SM);
    unf <= 1'b1;
    @(posedge clk);
    unf <= 1'b0;
    settle();
    rd(EPD_STATUS_OFS, 32'h0060_0020, SM);
    rd(EPD_STATUS_OFS, 32'h0060_0020, SM);
    chk("irq", 32'h1, {31'h0, irq});
    own <= 1'b0;
    apb(1'b1, EPD_TX_POLL_KICK_OFS, 32'h0);
    settle();
    rd(EPD_STATUS_OFS, 32'h0060_0024, SM);
    apb(1'b1, EPD_STATUS_OFS, 32'h0000_0020);
    rd(EPD_STATUS_OFS, 32'h0060_0004, SM);
    apb(1'b1, EPD_STATUS_OFS, 32'h0000_0004);
    rd(EPD_STATUS_OFS, 32'h0060_0000, SM);
    chk("irq", 32'h0, {31'h0, irq});
    own <= 1'b1;
    lat <= 4'h7;
    apb(1'b1, EPD_TX_POLL_KICK_OFS, 32'h1);
    settle();
    rd(EPD_STATUS_OFS, 32'h0030_0000, SM);
    chk("tx active", 32'h1, {31'h0, txa});
    chk("tx fetch addr", TXP, txf.addr);
    // Host-owned descriptor seen while running also suspends
    tu <= 1'b1;
    @(posedge clk);
    tu <= 1'b0;
    settle();
    rd(EPD_STATUS_OFS, 32'h0060_0004, SM);
    chk("tx active", 32'h0, {31'h0, txa});
    apb(1'b1, EPD_STATUS_OFS, 32'h0000_0004);
    apb(1'b1, EPD_TX_POLL_KICK_OFS, 32'h0);
    settle();
    rd(EPD_STATUS_OFS, 32'h0030_0000, SM);
    apb(1'b1, EPD_CONTROL_OFS, 32'h0000_2002);
    settle();
    chk("rx active", 32'h1, {31'h0, rxa});
    ru <= 1'b1;
    @(posedge clk);
    ru <= 1'b0;
    settle();
    rd(EPD_STATUS_OFS, 32'h0030_0080, SM);
    apb(1'b1, EPD_STATUS_OFS, 32'h0000_0080);
    own <= 1'b0;
    apb(1'b1, EPD_RX_POLL_KICK_OFS, 32'h5A5A_5A5A);
    settle();
    rd(EPD_STATUS_OFS, 32'h0030_0080, SM);
    own <= 1'b1;
    apb(1'b1, EPD_RX_POLL_KICK_OFS, 32'h0);
    settle();
    chk("rx active", 32'h1, {31'h0, rxa});
    chk("rx fetch addr", RXP, rxf.addr);
    give_verdict();
  end

  initial begin
    repeat (4000) @(posedge clk);
    fail_count++;
    give_verdict();
  end
endmodule : epd_top_bench
